// file: trm_defs.svh
// Register offsets, field positions, reset values and timing counts of the mixer
`ifndef TRM_DEFS_SVH
`define TRM_DEFS_SVH
`define TRM_OFF_PRESET   8'h00
`define TRM_OFF_TOGGLE   8'h04
`define TRM_OFF_POSTFADE 8'h08
`define TRM_OFF_RECEN    8'h0C
`define TRM_OFF_MEDIASEL 8'h10
`define TRM_OFF_TMEDIA0  8'h14
`define TRM_OFF_GAIN0    8'h20
`define TRM_OFF_PAIRCFG  8'h30
`define TRM_OFF_ARMED    8'h34
`define TRM_OFF_LIMACT   8'h38
`define TRM_OFF_MEDIACNT 8'h3C
`define TRM_TOG_IN_LSB   4
`define TRM_GAIN_UNITY_BIT 16
`define TRM_NUM_PRESETS  3'h6
`define TRM_FIRST_USER   3'h3
`define TRM_ROUTE_FACTORY 96'h0000_0000_2010_0804_0201_2A15
`define TRM_ROUTE_ISO     96'h0000_8040_2010_0804_0201_0000
`define TRM_ROUTE_MIX     96'h0000_0000_0000_0000_0000_FFFF
`define TRM_RST_POSTFADE 12'h003
`define TRM_RST_RECEN    12'h0FF
`define TRM_RST_TMEDIA   12'hFFF
`define TRM_RST_MEDIASEL 3'h7
`define TRM_GAIN_MIN     (-16'sd600)
`define TRM_GAIN_MAX     16'sd150
`define TRM_GAIN_OFFSET  16'sd600
`define TRM_GAIN_STEPS_6DB 16'sd60
`define TRM_LIM_UNITY    8'hFF
`define TRM_LIM_ATTACK   8'h08
`define TRM_CLK_KHZ      50000
`define TRM_BLINK_MS     250
`define TRM_ALT_MS       1000
`define TRM_BLINK_CYC    (`TRM_BLINK_MS * `TRM_CLK_KHZ)
`define TRM_ALT_CYC      (`TRM_ALT_MS * `TRM_CLK_KHZ)
`endif

// file: trm_pkg.sv
// Types shared by the track routing and arming mixer
package trm_pkg;
  typedef logic signed [23:0] trm_sample_type;
  typedef logic [11:0][7:0]   trm_route_type;
  typedef enum logic [1:0] {
    TRM_LIM_OFF = 2'b00,
    TRM_LIM_IND = 2'b01,
    TRM_LIM_LNK = 2'b10
  } trm_lim_mode_type;
  typedef struct packed {
    logic [7:0][23:0] trim;
    logic [7:0][23:0] fade;
  } trm_audio_in_type;
  typedef struct packed {
    logic        valid;
    logic        unity;
    logic [1:0]  idx;
    logic [15:0] val;
  } trm_ctl_gain_type;
  typedef struct packed {
    logic [2:0]                  preset;
    logic [2:0][11:0][7:0]       user;
    logic [11:0]                 postfade;
    logic [11:0]                 rec_en;
    logic [2:0]                  media_sel;
    logic [2:0][11:0]            tmedia;
    logic [3:0][15:0]            gain;
    logic [1:0]                  link;
    trm_lim_mode_type [1:0]      limmode;
    logic [3:0][7:0]             lgain;
    logic [26:0]                 blink_cnt;
    logic                        blink;
    logic [26:0]                 alt_cnt;
    logic                        alt;
    logic [11:0]                 armed;
    logic [11:0]                 led;
    logic [2:0][11:0]            wr;
    logic [2:0]                  show_cnt;
    logic [2:0][3:0]             cnt;
    logic [11:0][23:0]           trk;
    logic                        trk_valid;
    logic [3:0]                  limact;
    logic [31:0]                 prdata;
  } trm_state_type;
endpackage

// file: trm_core.sv
// Track routing, arming, media masking, master gain and track limiting
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "trm_defs.svh"
module trm_core #(
  parameter int BLINK_CYC = `TRM_BLINK_CYC,
  parameter int ALT_CYC   = `TRM_ALT_CYC
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire trm_pkg::trm_audio_in_type aud_in,
  input  wire logic                      aud_valid,
  input  wire logic [7:0]                input_on,
  input  wire logic [22:0]               lim_thresh,
  input  wire logic                      ctl_attached,
  input  wire trm_pkg::trm_ctl_gain_type ctl_gain,
  output logic      [11:0][23:0]         trk_out,
  output logic                           trk_valid,
  output logic      [11:0]               armed,
  output logic      [11:0]               track_led,
  output logic      [2:0][11:0]          media_wr,
  output logic      [2:0]                media_show_cnt,
  output logic      [2:0][3:0]           media_trk_cnt,
  output logic      [3:0]                lim_active
);
  import trm_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] clamp_gain(input logic [15:0] v);
    logic signed [15:0] sv;
    sv = signed'(v);
    if (sv < `TRM_GAIN_MIN) begin
      return `TRM_GAIN_MIN;
    end else if (sv > `TRM_GAIN_MAX) begin
      return `TRM_GAIN_MAX;
    end
    return v;
  endfunction

  function automatic logic [23:0] sat24(input logic signed [47:0] v);
    if (v > 48'sh7F_FFFF) begin
      return 24'h7F_FFFF;
    end else if (v < -48'sh80_0000) begin
      return 24'h80_0000;
    end
    return v[23:0];
  endfunction

  function automatic logic [3:0] popcnt(input logic [11:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int b = 0; b < 12; b++) begin
      c = c + 4'(v[b]);
    end
    return c;
  endfunction

  // Master gain index to track number: L, R, aux_track_one, aux_track_two
  function automatic int mtrk(input int k);
    return (k < 2) ? k : k + 8;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  trm_state_type s_r;
  trm_state_type s_nxt;

  logic          acc;
  logic          wr_en;
  logic          mapped;
  trm_route_type route;

  assign acc   = psel & penable;
  assign wr_en = acc & pwrite;

  always_comb begin
    mapped = (paddr[1:0] == 2'b00) && (paddr <= `TRM_OFF_MEDIACNT);
  end

  always_comb begin
    unique case (s_r.preset)
      3'h0: route = `TRM_ROUTE_FACTORY;
      3'h1: route = `TRM_ROUTE_ISO;
      3'h2: route = `TRM_ROUTE_MIX;
      3'h3: route = s_r.user[0];
      3'h4: route = s_r.user[1];
      3'h5: route = s_r.user[2];
      default: route = `TRM_ROUTE_FACTORY;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic signed [26:0] sum [12];
    logic signed [23:0] tap;
    logic signed [47:0] prod [4];
    logic signed [47:0] lim  [4];
    logic signed [47:0] mag;
    logic [3:0]         over;
    logic [9:0]         goff;
    logic [3:0]         sh;
    logic [5:0]         fr;
    logic [3:0]         ti;
    logic [2:0]         ii;
    logic [2:0]         us;
    logic [15:0]        gv;
    logic [1:0]         gk;
    logic               gset;
    logic [7:0]         g;
    logic [3:0]         na;
    s_nxt = s_r;
    for (int t = 0; t < 12; t++) begin
      sum[t] = 27'sh0;
    end
    tap  = 24'sh0;
    mag  = 48'sh0;
    over = 4'h0;
    goff = 10'h0;
    sh   = 4'h0;
    fr   = 6'h0;
    ti   = pwdata[3:0];
    ii   = pwdata[`TRM_TOG_IN_LSB +: 3];
    us   = 3'(s_r.preset - `TRM_FIRST_USER);
    gv   = 16'h0;
    gk   = 2'h0;
    gset = 1'b0;
    g    = 8'h0;
    na   = 4'h0;
    for (int k = 0; k < 4; k++) begin
      prod[k] = 48'sh0;
      lim[k]  = 48'sh0;
    end

    // Register writes
    if (wr_en) begin
      unique case (paddr)
        `TRM_OFF_PRESET: begin
          if (pwdata[2:0] < `TRM_NUM_PRESETS) begin
            s_nxt.preset = pwdata[2:0];
          end
        end
        `TRM_OFF_TOGGLE: begin
          if (s_r.preset >= `TRM_FIRST_USER && ti < 4'hC) begin
            s_nxt.user[us][ti][ii] = ~s_r.user[us][ti][ii];
          end
        end
        `TRM_OFF_POSTFADE: s_nxt.postfade = pwdata[11:0];
        `TRM_OFF_RECEN:    s_nxt.rec_en   = pwdata[11:0];
        `TRM_OFF_MEDIASEL: s_nxt.media_sel = pwdata[2:0];
        `TRM_OFF_TMEDIA0:         s_nxt.tmedia[0] = pwdata[11:0];
        `TRM_OFF_TMEDIA0 + 8'h04: s_nxt.tmedia[1] = pwdata[11:0];
        `TRM_OFF_TMEDIA0 + 8'h08: s_nxt.tmedia[2] = pwdata[11:0];
        `TRM_OFF_GAIN0, `TRM_OFF_GAIN0 + 8'h04,
        `TRM_OFF_GAIN0 + 8'h08, `TRM_OFF_GAIN0 + 8'h0C: begin
          gset = ~ctl_attached;
          gk   = paddr[3:2];
          gv   = pwdata[`TRM_GAIN_UNITY_BIT] ? 16'h0000 : clamp_gain(pwdata[15:0]);
        end
        `TRM_OFF_PAIRCFG: begin
          s_nxt.link       = pwdata[1:0];
          s_nxt.limmode[0] = (pwdata[3:2] == 2'b11) ? TRM_LIM_OFF
                                                    : trm_lim_mode_type'(pwdata[3:2]);
          s_nxt.limmode[1] = (pwdata[5:4] == 2'b11) ? TRM_LIM_OFF
                                                    : trm_lim_mode_type'(pwdata[5:4]);
        end
        default: ;
      endcase
    end

    if (ctl_attached && ctl_gain.valid) begin
      gset = 1'b1;
      gk   = ctl_gain.idx;
      gv   = ctl_gain.unity ? 16'h0000 : clamp_gain(ctl_gain.val);
    end
    // set one gain or both of a linked pair
    if (gset) begin
      s_nxt.gain[gk] = gv;
      if (s_r.link[gk[1]]) begin
        s_nxt.gain[gk ^ 2'h1] = gv;
      end
    end

    for (int t = 0; t < 12; t++) begin
      for (int i = 0; i < 8; i++) begin
        tap = s_r.postfade[t] ? signed'(aud_in.fade[i]) : signed'(aud_in.trim[i]);
        if (route[t][i] && input_on[i]) begin
          sum[t] = sum[t] + 27'(tap);
        end
      end
    end

    // master gain, 6 dB per shift, linear within the step
    for (int k = 0; k < 4; k++) begin
      goff    = 10'(signed'(s_r.gain[k]) + `TRM_GAIN_OFFSET);
      sh      = 4'(goff / 10'(`TRM_GAIN_STEPS_6DB));
      fr      = 6'(goff % 10'(`TRM_GAIN_STEPS_6DB));
      prod[k] = ((48'(sum[mtrk(k)]) * signed'(48'(7'h40 + 7'(fr)))) <<< sh) >>> 16;
      lim[k]  = (prod[k] * signed'(48'(s_r.lgain[k]))) >>> 8;
      mag     = (lim[k] < 0) ? -lim[k] : lim[k];
      over[k] = mag > signed'(48'(lim_thresh));
    end

    // Track outputs on each sample
    s_nxt.trk_valid = aud_valid;
    if (aud_valid) begin
      for (int t = 0; t < 12; t++) begin
        s_nxt.trk[t] = sat24(48'(sum[t]));
      end
      for (int k = 0; k < 4; k++) begin
        if (s_r.limmode[k/2] == TRM_LIM_OFF) begin
          s_nxt.trk[mtrk(k)] = sat24(prod[k]);
        end else if (over[k]) begin
          s_nxt.trk[mtrk(k)] = lim[k] < 0 ? sat24(-48'(lim_thresh))
                                          : sat24(48'(lim_thresh));
        end else begin
          s_nxt.trk[mtrk(k)] = sat24(lim[k]);
        end
      end
      for (int p = 0; p < 2; p++) begin
        unique case (s_r.limmode[p])
          TRM_LIM_OFF: begin
            s_nxt.lgain[2*p]   = `TRM_LIM_UNITY;
            s_nxt.lgain[2*p+1] = `TRM_LIM_UNITY;
          end
          TRM_LIM_IND: begin
            for (int q = 2*p; q < 2*p+2; q++) begin
              g = s_r.lgain[q];
              s_nxt.lgain[q] = over[q] ? ((g > `TRM_LIM_ATTACK) ? g - `TRM_LIM_ATTACK : 8'h00)
                                       : ((g == `TRM_LIM_UNITY) ? g : g + 8'h01);
            end
          end
          TRM_LIM_LNK: begin
            g = (s_r.lgain[2*p] < s_r.lgain[2*p+1]) ? s_r.lgain[2*p] : s_r.lgain[2*p+1];
            g = (over[2*p] | over[2*p+1])
                ? ((g > `TRM_LIM_ATTACK) ? g - `TRM_LIM_ATTACK : 8'h00)
                : ((g == `TRM_LIM_UNITY) ? g : g + 8'h01);
            s_nxt.lgain[2*p]   = g;
            s_nxt.lgain[2*p+1] = g;
          end
          default: ;
        endcase
      end
    end

    for (int k = 0; k < 4; k++) begin
      s_nxt.limact[k] = (s_r.limmode[k/2] != TRM_LIM_OFF) && (s_r.lgain[k] != `TRM_LIM_UNITY);
    end

    // Flash and display alternation timers
    if (s_r.blink_cnt >= 27'(BLINK_CYC - 1)) begin
      s_nxt.blink_cnt = 27'h0;
      s_nxt.blink     = ~s_r.blink;
    end else begin
      s_nxt.blink_cnt = s_r.blink_cnt + 27'h1;
    end
    if (s_r.alt_cnt >= 27'(ALT_CYC - 1)) begin
      s_nxt.alt_cnt = 27'h0;
      s_nxt.alt     = ~s_r.alt;
    end else begin
      s_nxt.alt_cnt = s_r.alt_cnt + 27'h1;
    end

    // status registered one cycle after any change
    for (int t = 0; t < 12; t++) begin
      s_nxt.armed[t] = s_r.rec_en[t] && |(route[t] & input_on)
                       && |{s_r.tmedia[2][t], s_r.tmedia[1][t], s_r.tmedia[0][t]};
    end
    s_nxt.led = s_nxt.armed | (s_r.rec_en & {12{s_r.blink}});
    na = popcnt(s_nxt.armed);
    for (int m = 0; m < 3; m++) begin
      s_nxt.wr[m]  = s_r.media_sel[m] ? (s_r.tmedia[m] & s_nxt.armed) : 12'h000;
      s_nxt.cnt[m] = popcnt(s_nxt.wr[m]);
      s_nxt.show_cnt[m] = s_r.media_sel[m] && (s_nxt.cnt[m] < na) && s_r.alt;
    end

    // Read data captured in the setup phase
    if (psel && !penable) begin
      unique case (paddr)
        `TRM_OFF_PRESET:          s_nxt.prdata = {29'h0, s_r.preset};
        `TRM_OFF_POSTFADE:        s_nxt.prdata = {20'h0, s_r.postfade};
        `TRM_OFF_RECEN:           s_nxt.prdata = {20'h0, s_r.rec_en};
        `TRM_OFF_MEDIASEL:        s_nxt.prdata = {29'h0, s_r.media_sel};
        `TRM_OFF_TMEDIA0:         s_nxt.prdata = {20'h0, s_r.tmedia[0]};
        `TRM_OFF_TMEDIA0 + 8'h04: s_nxt.prdata = {20'h0, s_r.tmedia[1]};
        `TRM_OFF_TMEDIA0 + 8'h08: s_nxt.prdata = {20'h0, s_r.tmedia[2]};
        `TRM_OFF_GAIN0:           s_nxt.prdata = {16'h0, s_r.gain[0]};
        `TRM_OFF_GAIN0 + 8'h04:   s_nxt.prdata = {16'h0, s_r.gain[1]};
        `TRM_OFF_GAIN0 + 8'h08:   s_nxt.prdata = {16'h0, s_r.gain[2]};
        `TRM_OFF_GAIN0 + 8'h0C:   s_nxt.prdata = {16'h0, s_r.gain[3]};
        `TRM_OFF_PAIRCFG:         s_nxt.prdata = {26'h0, s_r.limmode[1], s_r.limmode[0],
                                                  s_r.link};
        `TRM_OFF_ARMED:           s_nxt.prdata = {20'h0, s_r.armed};
        `TRM_OFF_LIMACT:          s_nxt.prdata = {28'h0, s_r.limact};
        `TRM_OFF_MEDIACNT:        s_nxt.prdata = {17'h0, s_r.show_cnt, s_r.cnt[2],
                                                  s_r.cnt[1], s_r.cnt[0]};
        default:                  s_nxt.prdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r           <= '0;
      s_r.user      <= {3{`TRM_ROUTE_FACTORY}};
      s_r.postfade  <= `TRM_RST_POSTFADE;
      s_r.rec_en    <= `TRM_RST_RECEN;
      s_r.media_sel <= `TRM_RST_MEDIASEL;
      s_r.tmedia    <= {3{`TRM_RST_TMEDIA}};
      s_r.lgain     <= {4{`TRM_LIM_UNITY}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata         = s_r.prdata;
  assign pready         = 1'b1;
  assign pslverr        = acc & ~mapped;
  assign trk_out        = s_r.trk;
  assign trk_valid      = s_r.trk_valid;
  assign armed          = s_r.armed;
  assign track_led      = s_r.led;
  assign media_wr       = s_r.wr;
  assign media_show_cnt = s_r.show_cnt;
  assign media_trk_cnt  = s_r.cnt;
  assign lim_active     = s_r.limact;

endmodule // trm_core

// file: trm_core_properties.sv
// Port checker for the mixer core with its bind
`timescale 1ns/10ps
module trm_core_checker #(
  parameter int BLINK_CYC = 4,
  parameter int ALT_CYC   = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pslverr,
  input wire logic              aud_valid,
  input wire logic [7:0]        input_on,
  input wire logic [22:0]       lim_thresh,
  input wire logic [11:0][23:0] trk_out,
  input wire logic              trk_valid,
  input wire logic [11:0]       armed,
  input wire logic [11:0]       track_led,
  input wire logic [2:0][11:0]  media_wr,
  input wire logic [2:0]        media_show_cnt,
  input wire logic [2:0][3:0]   media_trk_cnt,
  input wire logic [3:0]        lim_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Bus and stream timing
  // ----------------------------------------
  err_in_access_a: assert property (pslverr |-> psel && penable)
    else $error("error flag outside access phase");
  sample_follow_a: assert property (aud_valid |=> trk_valid)
    else $error("track sample missing after input sample");
  sample_cause_a: assert property (trk_valid |-> $past(aud_valid))
    else $error("track sample without input sample");
  // ----------------------------------------
  // Arming, media and limiting
  // ----------------------------------------
  // steady when armed
  led_armed_a: assert property ((armed & ~track_led) == 12'h000)
    else $error("armed track with dark indicator");
  write_armed_a: assert property (((media_wr[0] | media_wr[1] | media_wr[2]) & ~armed) == 12'h000)
    else $error("unarmed track written to a medium");
  all_off_a: assert property (input_on == 8'h00 |=> armed == 12'h000)
    else $error("track armed with every input off");
  show_count_a: assert property (media_show_cnt[0] |-> int'(media_trk_cnt[0]) < $countones(armed))
    else $error("track count shown for a full medium");
  lim_clamp_a: assert property (trk_valid && lim_active[0] |->
    (trk_out[0][23] ? (-$signed(trk_out[0]) <= $signed({1'b0, lim_thresh}))
                    : (trk_out[0] <= {1'b0, lim_thresh})))
    else $error("limited sample above threshold");
endmodule // trm_core_checker

bind trm_core trm_core_checker #(.BLINK_CYC(BLINK_CYC), .ALT_CYC(ALT_CYC)) trm_core_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr),
  .aud_valid(aud_valid), .input_on(input_on), .lim_thresh(lim_thresh), .trk_out(trk_out),
  .trk_valid(trk_valid), .armed(armed), .track_led(track_led), .media_wr(media_wr),
  .media_show_cnt(media_show_cnt), .media_trk_cnt(media_trk_cnt), .lim_active(lim_active)
);

// file: trm_panel_model.sv
// Model of the attached fader controller
`timescale 1ns/10ps
module trm_panel_model (
  input  wire logic             pclk,
  input  wire logic             attach,
  input  wire logic             fire,
  input  wire logic [1:0]       idx,
  input  wire logic [15:0]      val,
  output logic                  ctl_attached,
  output trm_pkg::trm_ctl_gain_type ctl_gain
);
  import trm_pkg::*;
  always @(posedge pclk) begin
    ctl_attached <= attach;
    ctl_gain.valid <= fire;
    ctl_gain.unity <= 1'b0;
    ctl_gain.idx <= idx;
    ctl_gain.val <= val;
  end
endmodule // trm_panel_model

// file: track_routing_arming_mixer_test.sv
// Testbench for the track routing and arming mixer
`timescale 1ns/10ps
module track_routing_arming_mixer_test;
  import trm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, aud_valid, trk_valid;
  logic attach, fire, ctl_attached, e, hi, lo;
  logic [7:0] paddr, input_on;
  logic [31:0] pwdata, prdata, r;
  logic [22:0] lim_thresh;
  logic [15:0] cval;
  logic [1:0] cidx;
  logic [11:0][23:0] trk_out;
  logic [11:0] armed, track_led;
  logic [2:0][11:0] media_wr;
  logic [2:0] media_show_cnt;
  logic [2:0][3:0] media_trk_cnt;
  logic [3:0] lim_active;
  trm_audio_in_type aud_in;
  trm_ctl_gain_type ctl_gain;
  int n_mismatch, total_checks, cyc;
  logic [7:0] ra[7] = '{8'h00, 8'h34, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
  logic [31:0] rx[7] = '{32'h0, 32'hFF, 32'h3, 32'hFF, 32'h7, 32'hFFF, 32'hFFF};
  logic [31:0] px[3] = '{32'h0FF, 32'h0FC, 32'h003};

  trm_core #(.BLINK_CYC(4), .ALT_CYC(8)) trm_core_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .aud_in(aud_in), .aud_valid(aud_valid), .input_on(input_on), .lim_thresh(lim_thresh),
    .ctl_attached(ctl_attached), .ctl_gain(ctl_gain), .trk_out(trk_out),
    .trk_valid(trk_valid), .armed(armed), .track_led(track_led), .media_wr(media_wr),
    .media_show_cnt(media_show_cnt), .media_trk_cnt(media_trk_cnt), .lim_active(lim_active));
  trm_panel_model trm_panel_model_inst (.pclk(pclk), .attach(attach), .fire(fire),
    .idx(cidx), .val(cval), .ctl_attached(ctl_attached), .ctl_gain(ctl_gain));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task automatic smp(input logic [23:0] f, input logic [23:0] t);
    for (int i = 0; i < 8; i++) begin
      aud_in.fade[i] <= f;
      aud_in.trim[i] <= t;
    end
    aud_valid <= 1'b1;
    @(posedge pclk);
    aud_valid <= 1'b0;
    @(negedge pclk);
    chk(32'(trk_valid), 32'h1);
    @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, aud_valid, attach, fire} = '0;
    {paddr, pwdata, cidx, cval} = '0;
    aud_in = '0;
    input_on = 8'hFF;
    lim_thresh = 23'h000100;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    tick(2);
    chk(32'(armed), 32'h0FF);
    foreach (ra[i]) rd(ra[i], rx[i]);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(e), 32'h1);
    smp(24'h000100, 24'h000055);
    chk(32'(trk_out[0]), 32'h300);
    chk(32'(trk_out[2]), 32'h055);
    chk(32'(trk_out[8]), 32'h0);
    wr(8'h08, 32'h7);
    smp(24'h000100, 24'h000055);
    chk(32'(trk_out[2]), 32'h100);
    wr(8'h20, 32'hFFC4);
    smp(24'h000100, 24'h000055);
    chk(32'(trk_out[0]), 32'h180);
    chk(32'(trk_out[1]), 32'h300);
    wr(8'h30, 32'h4);
    smp(24'h000100, 24'h000055);
    smp(24'h000100, 24'h000055);
    chk(32'(lim_active), 32'h3);
    wr(8'h30, 32'h0);
    lim_thresh <= 23'h000200;
    smp(24'h000100, 24'h000055);
    wr(8'h30, 32'h4);
    smp(24'h000100, 24'h000055);
    smp(24'h000100, 24'h000055);
    chk(32'(lim_active), 32'h2);
    wr(8'h30, 32'h8);
    smp(24'h000100, 24'h000055);
    smp(24'h000100, 24'h000055);
    chk(32'(lim_active), 32'h3);
    chk(32'(trk_out[1]), 32'h200);
    wr(8'h30, 32'h0);
    wr(8'h20, 32'h7FFF);
    rd(8'h20, 32'h0096);
    wr(8'h20, 32'hFD44);
    rd(8'h20, 32'hFDA8);
    wr(8'h20, 32'h10000);
    rd(8'h20, 32'h0);
    attach <= 1'b1;
    tick(2);
    wr(8'h20, 32'h10);
    rd(8'h20, 32'h0);
    cval <= 16'h0032;
    fire <= 1'b1;
    tick(1);
    fire <= 1'b0;
    tick(3);
    rd(8'h20, 32'h32);
    wr(8'h30, 32'h1);
    rd(8'h30, 32'h1);
    attach <= 1'b0;
    tick(2);
    wr(8'h20, 32'h14);
    rd(8'h24, 32'h14);
    wr(8'h30, 32'h0);
    input_on <= 8'hFE;
    tick(2);
    chk(32'(armed), 32'h0FB);
    {hi, lo} = '0;
    repeat (12) begin
      @(posedge pclk);
      hi |= track_led[2];
      lo |= ~track_led[2];
    end
    chk(32'({hi, lo, track_led[0], track_led[11]}), 32'hE);
    input_on <= 8'h00;
    tick(2);
    chk(32'(armed), 32'h0);
    input_on <= 8'hFF;
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 32'(i));
      tick(2);
      chk(32'(armed), px[i]);
    end
    wr(8'h00, 32'h6);
    rd(8'h00, 32'h2);
    wr(8'h0C, 32'hFFF);
    wr(8'h00, 32'h3);
    wr(8'h04, 32'h6B);
    tick(2);
    chk(32'(armed), 32'h8FF);
    wr(8'h04, 32'h6B);
    tick(2);
    chk(32'(armed), 32'h0FF);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h6B);
    tick(2);
    chk(32'(armed), 32'h0FF);
    wr(8'h0C, 32'h3);
    wr(8'h14, 32'h1);
    tick(2);
    chk(32'({media_wr[1], media_wr[0]}), 32'h003001);
    chk(32'(media_trk_cnt[0]), 32'h1);
    hi = 1'b0;
    repeat (20) begin
      @(posedge pclk);
      hi |= media_show_cnt[0];
    end
    chk(32'(hi), 32'h1);
    wr(8'h18, 32'h1);
    wr(8'h1C, 32'h1);
    tick(2);
    chk(32'(armed), 32'h001);
    wr(8'h10, 32'h1);
    tick(2);
    chk(32'(media_wr[1]), 32'h0);
    test_done();
  end
endmodule // track_routing_arming_mixer_test
